// file: i2cpe_defines.vh
// constants of the two-wire protocol engine
`ifndef I2CPE_DEFINES_VH
`define I2CPE_DEFINES_VH

// timing: clock period and serial clock period, in ns
`define I2CPE_CLK_PERIOD_NS 4
`define I2CPE_SCL_PERIOD_NS 10000
// a bit period is four quarter phases
`define I2CPE_QTR_CYC (`I2CPE_SCL_PERIOD_NS / (4 * `I2CPE_CLK_PERIOD_NS))
`define I2CPE_CNT_W 10

// master request codes
`define I2CPE_CMD_ADDR 2'h0
`define I2CPE_CMD_WRITE 2'h1
`define I2CPE_CMD_READ 2'h2
`define I2CPE_CMD_STOP 2'h3

// address patterns
`define I2CPE_TEN_PFX 5'h1E
`define I2CPE_RSV_HI 5'h1F
`define I2CPE_RSV_LO 4'h0

// bit counter marks within a byte
`define I2CPE_BIT_ACK 4'h8
`define I2CPE_BIT_POST 4'h9

`endif

// file: i2cpe_line_mon.v
// line synchroniser and start, stop and edge detector
`timescale 1ns/100ps
module i2cpe_line_mon (
  // system
  input wire clock,
  input wire reset_n,
  // raw bus levels
  input wire scl_in,
  input wire sda_in,
  // synchronised levels and events
  output wire scl_s,
  output wire sda_s,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det,
  output wire busy
);

  reg scl_m_q;
  reg sda_m_q;
  reg scl_s_q;
  reg sda_s_q;
  reg scl_p_q;
  reg sda_p_q;
  reg busy_q;

  //////////////////////////////////////////////////////////////////////////
  // three flops per line; levels come from the second stage, edges compare the second and third
  always @(posedge clock) begin
    if (!reset_n) begin
      scl_m_q <= 1'b1;
      sda_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      sda_m_q <= sda_in;
      scl_s_q <= scl_m_q;
      sda_s_q <= sda_m_q;
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_s = scl_s_q;
  assign sda_s = sda_s_q;
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  // data edge with the clock high both cycles
  assign start_det = sda_p_q & ~sda_s_q & scl_s_q & scl_p_q;
  assign stop_det = ~sda_p_q & sda_s_q & scl_s_q & scl_p_q;

  //////////////////////////////////////////////////////////////////////////
  // busy from a start until a stop
  always @(posedge clock) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1;
    end else if (stop_det) begin
      busy_q <= 1'b0;
    end
  end

  assign busy = busy_q;

endmodule

// file: i2cpe_engine.v
// two-wire bus protocol engine: master and slave byte sequencers
//
// Contract
// - a start is data falling while clock stays high.
// - a master stop is data rising while clock stays high.
// - data changes only with clock low, steady while clock high.
// - one bit per clock pulse, sampled once while clock is high.
// - as master, wait for an idle bus before the start.
// - after start send 7-bit address and direction, 1 read, 0 write.
// - master releases data in the address ack slot; slave pulls low.
// - after every eight bits the sender releases data for the ack.
// - address and data bytes go out most significant bit first.
// - no byte limit; master ends with a stop after an ack slot.
// - after stop any master may start; repeated start is allowed.
// - all-zero address is general call for write, start byte for read.
// - reserved seven-bit patterns are never ordinary slave addresses.
// - ten-bit first byte is 11110, two high bits, direction.
// - ten-bit second byte carries the eight low address bits.
// - as ten-bit slave, acknowledge both matching address bytes.
// - ten-bit master write sends both bytes then the data.
// - ten-bit read: both bytes, repeated start, first byte with read.
// - ten-bit slave remembers its match and answers the read.
// - the engine works as master and as addressed slave.
`timescale 1ns/100ps
`include "i2cpe_defines.vh"
module i2cpe_engine (
  // system
  input wire clock,
  input wire reset_n,
  // bus pins, open drain
  input wire scl_in,
  input wire sda_in,
  output wire scl_out,
  output wire scl_oe,
  output wire sda_out,
  output wire sda_oe,
  // master request
  input wire m_req_valid,
  output wire m_req_ready,
  input wire [1:0] m_req_cmd,
  input wire [9:0] m_req_addr,
  input wire m_req_ten,
  input wire m_req_rw,
  input wire [7:0] m_req_wdata,
  input wire m_req_nack,
  // master answer
  output wire m_rsp_valid,
  output wire m_rsp_nack,
  output wire [7:0] m_rsp_data,
  // slave configuration
  input wire s_en,
  input wire s_ten_en,
  input wire s_gc_en,
  input wire [9:0] s_own_addr,
  // slave data
  input wire [7:0] s_tx_data,
  output wire s_tx_load,
  output wire s_rx_valid,
  output wire [7:0] s_rx_data,
  output wire s_addr_hit,
  output wire s_addr_rw,
  output wire s_gcall,
  output wire s_stop,
  // status
  output wire bus_busy,
  output wire m_active
);

  localparam M_IDLE = 6'h01;
  localparam M_WAIT = 6'h02;
  localparam M_START = 6'h04;
  localparam M_BYTE = 6'h08;
  localparam M_HOLD = 6'h10;
  localparam M_STOP = 6'h20;

  localparam S_IDLE = 6'h01;
  localparam S_ADDR1 = 6'h02;
  localparam S_ADDR2 = 6'h04;
  localparam S_RX = 6'h08;
  localparam S_TX = 6'h10;
  localparam S_IGN = 6'h20;

  localparam integer QTR_I = `I2CPE_QTR_CYC - 1;
  localparam [`I2CPE_CNT_W-1:0] QTR_M1 = QTR_I[`I2CPE_CNT_W-1:0];

  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  reg [5:0] m_state_q;
  reg [1:0] m_ph_q;
  reg [`I2CPE_CNT_W-1:0] m_cnt_q;
  reg [3:0] m_bit_q;
  reg [7:0] m_sh_q;
  reg m_rx_q;
  reg m_nack_send_q;
  reg m_nack_got_q;
  reg m_inaddr_q;
  reg [1:0] m_aseq_q;
  reg [9:0] m_addr_q;
  reg m_ten_q;
  reg m_rw_q;
  reg m_scl_low_q;
  reg m_sda_low_q;
  reg m_rsp_valid_q;
  reg m_rsp_nack_q;
  reg [7:0] m_rsp_data_q;

  reg [5:0] s_state_q;
  reg [3:0] s_bit_q;
  reg [7:0] s_sh_q;
  reg s_sda_low_q;
  reg s_mack_q;
  reg s_ten_hit_q;
  reg s_tx_load_q;
  reg s_rx_valid_q;
  reg [7:0] s_rx_data_q;
  reg s_addr_hit_q;
  reg s_addr_rw_q;
  reg s_gcall_q;
  reg s_stop_q;

  //////////////////////////////////////////////////////////////////////////
  // first address byte, seven-bit or ten-bit head
  function [7:0] addr_head;
    input [9:0] a;
    input ten;
    input rw;
    begin
      if (ten) begin
        addr_head = {`I2CPE_TEN_PFX, a[9:8], rw};
      end else begin
        addr_head = {a[6:0], rw};
      end
    end
  endfunction

  // reserved seven-bit patterns, ten-bit heads included
  function rsv7;
    input [6:0] a;
    begin
      rsv7 = (a[6:3] == `I2CPE_RSV_LO) | (a[6:2] == `I2CPE_RSV_HI) |
             (a[6:2] == `I2CPE_TEN_PFX);
    end
  endfunction

  i2cpe_line_mon u_mon (
    .clock(clock),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .busy(bus_busy)
  );

  //////////////////////////////////////////////////////////////////////////
  // master sequencer
  // quarter phases: 0 set data, 1 free clock, 2 sample, 3 pull clock low.
  // phase 2 waits for the clock line to read high, so a slow rise or
  // another driver just lengthens the low phase.
  wire m_run = |(m_state_q & (M_START | M_BYTE | M_STOP));
  wire m_tick = m_run & (m_cnt_q == {`I2CPE_CNT_W{1'b0}}) &
                ((m_ph_q != 2'h2) | scl_s);
  wire m_own = |(m_state_q & (M_START | M_BYTE | M_HOLD | M_STOP));

  assign m_req_ready = m_state_q[0] | m_state_q[4];
  wire m_take = m_req_valid & m_req_ready;

  always @(posedge clock) begin
    if (!reset_n) begin
      m_state_q <= M_IDLE;
      m_ph_q <= 2'h0;
      m_cnt_q <= {`I2CPE_CNT_W{1'b0}};
      m_bit_q <= 4'h0;
      m_sh_q <= 8'h00;
      m_rx_q <= 1'b0;
      m_nack_send_q <= 1'b0;
      m_nack_got_q <= 1'b0;
      m_inaddr_q <= 1'b0;
      m_aseq_q <= 2'h0;
      m_addr_q <= 10'h000;
      m_ten_q <= 1'b0;
      m_rw_q <= 1'b0;
      m_scl_low_q <= 1'b0;
      m_sda_low_q <= 1'b0;
      m_rsp_valid_q <= 1'b0;
      m_rsp_nack_q <= 1'b0;
      m_rsp_data_q <= 8'h00;
    end else begin
      m_rsp_valid_q <= 1'b0;
      if (m_run & ~m_tick & (m_cnt_q != {`I2CPE_CNT_W{1'b0}})) begin
        m_cnt_q <= m_cnt_q - 1'b1;
      end else if (m_tick) begin
        m_cnt_q <= QTR_M1;
        m_ph_q <= m_ph_q + 1'b1;
      end
      case (m_state_q)
        M_IDLE: begin
          if (m_take & (m_req_cmd == `I2CPE_CMD_ADDR)) begin
            m_addr_q <= m_req_addr;
            m_ten_q <= m_req_ten;
            m_rw_q <= m_req_rw;
            m_aseq_q <= 2'h0;
            m_state_q <= M_WAIT;
          end
        end
        M_WAIT: begin
          if (!bus_busy) begin
            m_state_q <= M_START;
            m_ph_q <= 2'h0;
            m_cnt_q <= QTR_M1;
          end
        end
        M_HOLD: begin
          if (m_take) begin
            m_ph_q <= 2'h0;
            m_cnt_q <= QTR_M1;
            m_bit_q <= 4'h0;
            case (m_req_cmd)
              `I2CPE_CMD_ADDR: begin
                m_addr_q <= m_req_addr;
                m_ten_q <= m_req_ten;
                m_rw_q <= m_req_rw;
                m_aseq_q <= 2'h0;
                m_state_q <= M_START;
              end
              `I2CPE_CMD_WRITE: begin
                m_sh_q <= m_req_wdata;
                m_rx_q <= 1'b0;
                m_state_q <= M_BYTE;
              end
              `I2CPE_CMD_READ: begin
                m_rx_q <= 1'b1;
                m_nack_send_q <= m_req_nack;
                m_state_q <= M_BYTE;
              end
              default: begin
                m_state_q <= M_STOP;
              end
            endcase
          end
        end
        M_START: begin
          if (m_tick) begin
            case (m_ph_q)
              2'h0: m_sda_low_q <= 1'b0;
              2'h1: m_scl_low_q <= 1'b0;
              2'h2: m_sda_low_q <= 1'b1;
              default: begin
                m_scl_low_q <= 1'b1;
                m_bit_q <= 4'h0;
                m_rx_q <= 1'b0;
                m_inaddr_q <= 1'b1;
                // ten-bit heads go out as write except after the restart
                m_sh_q <= addr_head(m_addr_q, m_ten_q,
                  m_ten_q ? (m_aseq_q == 2'h3) : m_rw_q);
                m_state_q <= M_BYTE;
              end
            endcase
          end
        end
        M_BYTE: begin
          if (m_tick) begin
            case (m_ph_q)
              2'h0: begin
                if (m_bit_q != `I2CPE_BIT_ACK) begin
                  m_sda_low_q <= ~m_rx_q & ~m_sh_q[7];
                end else begin
                  m_sda_low_q <= m_rx_q & ~m_nack_send_q;
                end
              end
              2'h1: m_scl_low_q <= 1'b0;
              2'h2: begin
                // own bits are shifted back in from the line
                if (m_bit_q != `I2CPE_BIT_ACK) begin
                  m_sh_q <= {m_sh_q[6:0], sda_s};
                end else begin
                  m_nack_got_q <= sda_s;
                end
              end
              default: begin
                m_scl_low_q <= 1'b1;
                if (m_bit_q != `I2CPE_BIT_ACK) begin
                  m_bit_q <= m_bit_q + 1'b1;
                end else begin
                  m_bit_q <= 4'h0;
                  if (m_inaddr_q & ~m_nack_got_q & m_ten_q &
                      (m_aseq_q == 2'h0)) begin
                    m_sh_q <= m_addr_q[7:0];
                    m_aseq_q <= 2'h1;
                  end else if (m_inaddr_q & ~m_nack_got_q & m_ten_q &
                               m_rw_q & (m_aseq_q == 2'h1)) begin
                    m_aseq_q <= 2'h3;
                    m_state_q <= M_START;
                  end else begin
                    // address done or data byte done
                    m_inaddr_q <= 1'b0;
                    m_state_q <= M_HOLD;
                    m_rsp_valid_q <= 1'b1;
                    m_rsp_nack_q <= m_nack_got_q;
                    m_rsp_data_q <= m_sh_q;
                  end
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (m_tick) begin
            case (m_ph_q)
              2'h0: m_sda_low_q <= 1'b1;
              2'h1: m_scl_low_q <= 1'b0;
              2'h2: m_sda_low_q <= 1'b0;
              default: begin
                m_state_q <= M_IDLE;
                m_rsp_valid_q <= 1'b1;
                m_rsp_nack_q <= 1'b0;
              end
            endcase
          end
        end
        default: m_state_q <= M_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // slave sequencer, steered by line events
  // bit counter: 1..8 after data rises, 9 after the ack rise.
  // data is only moved on a seen clock fall, so it is steady while high.
  wire [7:0] s_byte = s_sh_q;
  wire s_head_hit = (s_byte[7:3] == `I2CPE_TEN_PFX) &
                    (s_byte[2:1] == s_own_addr[9:8]);

  always @(posedge clock) begin
    if (!reset_n) begin
      s_state_q <= S_IDLE;
      s_bit_q <= 4'h0;
      s_sh_q <= 8'h00;
      s_sda_low_q <= 1'b0;
      s_mack_q <= 1'b0;
      s_ten_hit_q <= 1'b0;
      s_tx_load_q <= 1'b0;
      s_rx_valid_q <= 1'b0;
      s_rx_data_q <= 8'h00;
      s_addr_hit_q <= 1'b0;
      s_addr_rw_q <= 1'b0;
      s_gcall_q <= 1'b0;
      s_stop_q <= 1'b0;
    end else begin
      s_tx_load_q <= 1'b0;
      s_rx_valid_q <= 1'b0;
      s_addr_hit_q <= 1'b0;
      s_stop_q <= 1'b0;
      if (!s_en | m_own) begin
        // own master transfer: the slave side stays out of it
        s_state_q <= S_IDLE;
        s_sda_low_q <= 1'b0;
        s_ten_hit_q <= 1'b0;
      end else if (start_det) begin
        // repeated start keeps the ten-bit match
        s_state_q <= S_ADDR1;
        s_bit_q <= 4'h0;
        s_sda_low_q <= 1'b0;
      end else if (stop_det) begin
        s_stop_q <= ~s_state_q[0];
        s_state_q <= S_IDLE;
        s_sda_low_q <= 1'b0;
        s_ten_hit_q <= 1'b0;
      end else if (scl_rise & ~s_state_q[0] & ~s_state_q[5]) begin
        if (s_bit_q < `I2CPE_BIT_ACK) begin
          s_sh_q <= {s_sh_q[6:0], sda_s};
        end else begin
          s_mack_q <= ~sda_s;
        end
        s_bit_q <= s_bit_q + 1'b1;
      end else if (scl_fall & ~s_state_q[0] & ~s_state_q[5]) begin
        if (s_bit_q == `I2CPE_BIT_ACK) begin
          case (s_state_q)
            S_ADDR1: begin
              if (s_gc_en & (s_byte == 8'h00)) begin
                s_sda_low_q <= 1'b1;
                s_gcall_q <= 1'b1;
                s_addr_hit_q <= 1'b1;
                s_addr_rw_q <= 1'b0;
                s_state_q <= S_RX;
              end else if (s_ten_en & s_head_hit & ~s_byte[0]) begin
                s_sda_low_q <= 1'b1;
                s_state_q <= S_ADDR2;
              end else if (s_ten_en & s_head_hit & s_byte[0] &
                           s_ten_hit_q) begin
                s_sda_low_q <= 1'b1;
                s_gcall_q <= 1'b0;
                s_addr_hit_q <= 1'b1;
                s_addr_rw_q <= 1'b1;
                s_state_q <= S_TX;
              end else if (~s_ten_en & ~rsv7(s_own_addr[6:0]) &
                           (s_byte[7:1] == s_own_addr[6:0])) begin
                s_sda_low_q <= 1'b1;
                s_gcall_q <= 1'b0;
                s_addr_hit_q <= 1'b1;
                s_addr_rw_q <= s_byte[0];
                s_state_q <= s_byte[0] ? S_TX : S_RX;
              end else begin
                s_state_q <= S_IGN;
              end
            end
            S_ADDR2: begin
              if (s_byte == s_own_addr[7:0]) begin
                s_sda_low_q <= 1'b1;
                s_ten_hit_q <= 1'b1;
                s_gcall_q <= 1'b0;
                s_addr_hit_q <= 1'b1;
                s_addr_rw_q <= 1'b0;
                s_state_q <= S_RX;
              end else begin
                s_ten_hit_q <= 1'b0;
                s_state_q <= S_IGN;
              end
            end
            S_RX: begin
              s_sda_low_q <= 1'b1;
              s_rx_valid_q <= 1'b1;
              s_rx_data_q <= s_byte;
            end
            default: begin
              s_sda_low_q <= 1'b0;
            end
          endcase
        end else if (s_bit_q == `I2CPE_BIT_POST) begin
          s_bit_q <= 4'h0;
          if (s_state_q == S_TX) begin
            // own ack reads back low, so the address slot counts too
            if (s_mack_q) begin
              s_sh_q <= s_tx_data;
              s_sda_low_q <= ~s_tx_data[7];
              s_tx_load_q <= 1'b1;
            end else begin
              s_sda_low_q <= 1'b0;
              s_state_q <= S_IGN;
            end
          end else begin
            s_sda_low_q <= 1'b0;
          end
        end else if ((s_state_q == S_TX) & (s_bit_q != 4'h0)) begin
          // the rise already shifted the sent bit back in
          s_sda_low_q <= ~s_sh_q[7];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pins: low or released only
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = m_scl_low_q;
  assign sda_oe = m_sda_low_q | s_sda_low_q;

  assign m_rsp_valid = m_rsp_valid_q;
  assign m_rsp_nack = m_rsp_nack_q;
  assign m_rsp_data = m_rsp_data_q;
  assign m_active = ~m_state_q[0];

  assign s_tx_load = s_tx_load_q;
  assign s_rx_valid = s_rx_valid_q;
  assign s_rx_data = s_rx_data_q;
  assign s_addr_hit = s_addr_hit_q;
  assign s_addr_rw = s_addr_rw_q;
  assign s_gcall = s_gcall_q;
  assign s_stop = s_stop_q;

endmodule

// file: i2cpe_engine_asserts.sv
// port checks of the protocol engine
`timescale 1ns/100ps
module i2cpe_engine_asserts (
  // system
  input wire clock,
  input wire reset_n,
  // bus pins
  input wire scl_in,
  input wire sda_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_out,
  input wire sda_oe,
  // master and slave status
  input wire m_req_ready,
  input wire m_rsp_valid,
  input wire s_addr_hit,
  input wire s_rx_valid,
  input wire bus_busy,
  input wire m_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  pull_only_a: assert property (!scl_out && !sda_out)
    else $error("line value not low");
  idle_ready_a: assert property (!m_active |-> m_req_ready)
    else $error("idle master not ready");
  rsp_pulse_a: assert property (m_rsp_valid |=> !m_rsp_valid)
    else $error("answer longer than a cycle");
  start_busy_a: assert property (!bus_busy && scl_in && $past(scl_in)
    && $fell(sda_in) |-> ##[1:6] bus_busy) else $error("start missed");
  stop_idle_a: assert property (bus_busy && scl_in && $past(scl_in)
    && $rose(sda_in) |-> ##[1:6] !bus_busy) else $error("stop missed");
  clk_pull_a: assert property ($rose(scl_oe) |-> bus_busy)
    else $error("clock pulled on idle bus");
  addr_ack_a: assert property (s_addr_hit |-> sda_oe [*4])
    else $error("address ack not held");
  rx_ack_a: assert property (s_rx_valid |-> sda_oe)
    else $error("data ack missing");
  hit_slave_a: assert property (s_addr_hit |-> bus_busy && !m_active)
    else $error("slave hit while master or idle");
endmodule
bind i2cpe_engine i2cpe_engine_asserts i_chk (
  .clock(clock), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .m_req_ready(m_req_ready), .m_rsp_valid(m_rsp_valid),
  .s_addr_hit(s_addr_hit), .s_rx_valid(s_rx_valid),
  .bus_busy(bus_busy), .m_active(m_active)
);

// file: i2cpe_bus_model.sv
// far side of the bus: fast master and a two-byte write slave
`timescale 1ns/100ps
module i2cpe_bus_model #(parameter [6:0] SLV_ADDR = 7'h51) (
  // bus levels
  input wire scl,
  input wire sda,
  // pulls toward low
  output wire scl_pull,
  output wire sda_pull
);
  reg m_scl = 0, m_sda = 0, s_sda = 0, mst_on = 0;
  reg [7:0] got [0:1];
  reg [7:0] sh;
  integer n, i;
  assign scl_pull = m_scl;
  assign sda_pull = m_sda | s_sda;
  ////////////////////////////////////////////////////////////////////////////
  // slave: address byte then one data byte, no stretching
  always @(negedge sda) if (scl === 1'b1 && !mst_on) begin
    for (n = 0; n < 2; n = n + 1) begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge scl);
        sh = {sh[6:0], sda};
      end
      got[n] = sh;
      @(negedge scl);
      #40 s_sda = (n == 1) || (sh[7:1] == SLV_ADDR);
      @(negedge scl);
      #40 s_sda = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // master: 32 ns bit, clock stands still outside frames
  task p_bit(input b, output r);
    begin
      #4 m_sda = !b;
      #12 m_scl = 0;
      #12 r = sda;
      #4 m_scl = 1;
    end
  endtask
  // start or repeated start, from idle or clock low
  task p_start;
    begin
      mst_on = 1;
      #4 m_sda = 0;
      #12 m_scl = 0;
      #8 m_sda = 1;
      #8 m_scl = 1;
    end
  endtask
  task p_stop;
    begin
      #4 m_sda = 1;
      #12 m_scl = 0;
      #8 m_sda = 0;
      #8 mst_on = 0;
    end
  endtask
  // reading passes d all ones; last is the bit in the ack slot
  task p_byte(input [7:0] d, input last, output [7:0] q, output ack_n);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        p_bit(d[k], q[k]);
      p_bit(last, ack_n);
    end
  endtask
endmodule

// file: i2cpe_engine_test.sv
// self-checking bench of the protocol engine against the bus model
`timescale 1ns/100ps
`include "i2cpe_defines.vh"
module i2cpe_engine_test;
  reg clock = 0, reset_n = 0, m_req_valid = 0, m_req_nack = 0;
  reg m_req_ten = 0, m_req_rw = 0, s_en = 0, s_ten_en = 0, s_gc_en = 0;
  reg [1:0] m_req_cmd = 2'h0;
  reg [9:0] m_req_addr = 10'h000, s_own_addr = 10'h02A;
  reg [7:0] m_req_wdata = 8'h00, s_tx_data = 8'h96, rx_last = 8'h00, q;
  reg rw_last = 0, gc_last = 0, ack_n;
  wire scl_oe, sda_oe, m_req_ready, m_rsp_valid, m_rsp_nack, s_rx_valid;
  wire s_addr_hit, s_addr_rw, s_gcall, bus_busy, scl_pull, sda_pull, m_active;
  wire [7:0] s_rx_data, m_rsp_data;
  wire scl = !(scl_oe | scl_pull);
  wire sda = !(sda_oe | sda_pull);
  integer error_cnt = 0, cmp_count = 0, hi_chg = 0, w;
  // slave variants: own address, address byte, general call, nack
  localparam [16:0] TBL [0:5] = '{{7'h2A, 8'h54, 2'b00},
    {7'h2A, 8'h56, 2'b01}, {7'h7C, 8'hF8, 2'b01}, {7'h04, 8'h08, 2'b01},
    {7'h2A, 8'h00, 2'b10}, {7'h2A, 8'h01, 2'b11}};
  i2cpe_engine i_i2cpe_engine (
    .clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
    .m_req_valid(m_req_valid), .m_req_ready(m_req_ready),
    .m_req_cmd(m_req_cmd), .m_req_addr(m_req_addr), .m_req_ten(m_req_ten),
    .m_req_rw(m_req_rw), .m_req_wdata(m_req_wdata), .m_req_nack(m_req_nack),
    .m_rsp_valid(m_rsp_valid), .m_rsp_nack(m_rsp_nack),
    .m_rsp_data(m_rsp_data),
    .s_en(s_en), .s_ten_en(s_ten_en), .s_gc_en(s_gc_en),
    .s_own_addr(s_own_addr), .s_tx_data(s_tx_data), .s_tx_load(),
    .s_rx_valid(s_rx_valid), .s_rx_data(s_rx_data),
    .s_addr_hit(s_addr_hit), .s_addr_rw(s_addr_rw), .s_gcall(s_gcall),
    .s_stop(), .bus_busy(bus_busy), .m_active(m_active)
  );
  i2cpe_bus_model i_i2cpe_bus_model (
    .scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull)
  );
  initial forever #2 clock = !clock;
  // levels seen at slave pulses; data edges with clock high counted
  always @(posedge clock) begin
    if (s_rx_valid === 1'b1) rx_last <= s_rx_data;
    if (s_addr_hit === 1'b1) rw_last <= s_addr_rw;
    if (s_addr_hit === 1'b1) gc_last <= s_gcall;
  end
  always @(sda) if (scl === 1'b1) hi_chg = hi_chg + 1;
  ////////////////////////////////////////////////////////////////////////////
  task conclude;
    begin
      if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [9:0] got, input [9:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task tmo(input t);
    if (t) begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  endtask
  task ps; i_i2cpe_bus_model.p_start; endtask
  task pp; i_i2cpe_bus_model.p_stop; endtask
  task pb(input [7:0] d, input l); i_i2cpe_bus_model.p_byte(d, l, q, ack_n);
  endtask
  // request is held until a negedge shows ready, so the next edge takes it
  task m_req(input [1:0] c, input [7:0] d);
    begin
      @(negedge clock);
      m_req_cmd = c;
      m_req_wdata = d;
      m_req_valid = 1'b1;
      for (w = 0; w < 50 && m_req_ready !== 1'b1; w = w + 1) @(negedge clock);
      tmo(w == 50);
      @(negedge clock);
      m_req_valid = 1'b0;
    end
  endtask
  task m_rsp(input e);
    begin
      for (w = 0; w < 40000 && m_rsp_valid !== 1'b1; w = w + 1)
        @(negedge clock);
      tmo(w == 40000);
      chk("rsp nack", m_rsp_nack, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_slave7;
    integer k;
    reg [16:0] e;
    for (k = 0; k < 6; k = k + 1) begin
      e = TBL[k];
      @(negedge clock);
      s_own_addr = {3'b000, e[16:10]};
      s_gc_en = e[1];
      ps;
      pb(e[9:2], 1'b1);
      chk("addr ack", ack_n, e[0]);
      if (!e[0]) pb(8'hC0 + k[7:0], 1'b1);
      if (!e[0]) chk("data ack", ack_n, 1'b0);
      pp;
      repeat (8) @(negedge clock);
      chk("busy", bus_busy, 1'b0);
      if (!e[0]) chk("rx", rx_last, 8'hC0 + k[7:0]);
      if (!e[0]) chk("gcall", gc_last, e[9:2] == 8'h00);
    end
  endtask
  task t_slave10;
    begin
      @(negedge clock);
      s_ten_en = 1'b1;
      s_own_addr = 10'h2B4;
      ps;
      pb(8'hF4, 1'b1);
      chk("head ack", ack_n, 1'b0);
      pb(8'hB4, 1'b1);
      chk("low ack", ack_n, 1'b0);
      pb(8'h3D, 1'b1);
      ps;
      pb(8'hF5, 1'b1);
      chk("read ack", ack_n, 1'b0);
      pb(8'hFF, 1'b1);
      chk("tx data", q, 8'h96);
      pp;
      chk("rx", rx_last, 8'h3D);
      chk("dir", rw_last, 1'b1);
      ps;
      pb(8'hF5, 1'b1);
      chk("fresh read", ack_n, 1'b1);
      pp;
      s_ten_en = 1'b0;
      s_own_addr = 10'h02A;
    end
  endtask
  task t_master;
    begin
      m_req_addr = 10'h051;
      ps;
      m_req(`I2CPE_CMD_ADDR, 8'h00);
      repeat (200) @(negedge clock);
      chk("wait pull", {scl_oe, sda_oe, m_active}, 3'b001);
      pp;
      hi_chg = 0;
      m_rsp(1'b0);
      m_req(`I2CPE_CMD_WRITE, 8'h3C);
      m_rsp(1'b0);
      chk("wr back", m_rsp_data, 8'h3C);
      // nobody drives data, so a read sees all ones; own nack ends it
      m_req_nack = 1'b1;
      m_req(`I2CPE_CMD_READ, 8'h00);
      m_rsp(1'b1);
      chk("rd data", m_rsp_data, 8'hFF);
      m_req(`I2CPE_CMD_STOP, 8'h00);
      m_rsp(1'b0);
      repeat (40) @(negedge clock);
      chk("addr byte", i_i2cpe_bus_model.got[0], 8'hA2);
      chk("data byte", i_i2cpe_bus_model.got[1], 8'h3C);
      chk("high edges", hi_chg, 10'd2);
      chk("released", {scl_oe, sda_oe, bus_busy}, 3'b000);
    end
  endtask
  initial begin
    repeat (12) @(negedge clock);
    chk("reset", {scl_oe, sda_oe, bus_busy, m_req_ready}, 4'h1);
    reset_n = 1'b1;
    s_en = 1'b1;
    repeat (4) @(negedge clock);
    t_slave7;
    t_slave10;
    t_master;
    conclude;
  end
endmodule
